/* include/vpc_pkg.sv */
// constants, register map and carrier types for the reference and power-good control block
package vpc_pkg;

	localparam int unsigned CLK_NS = 40;

	// command codes of the register map
	localparam logic [7:0] CMD_OUTPUT_CODE = 8'h21;
	localparam logic [7:0] CMD_LP_PHASE    = 8'hD1;
	localparam logic [7:0] CMD_CFG_A       = 8'hD2;
	localparam logic [7:0] CMD_CFG_B       = 8'hD3;
	localparam logic [7:0] CMD_SLEW        = 8'hD6;
	localparam logic [7:0] CMD_TRIM        = 8'hDB;
	localparam logic [7:0] CMD_CAL         = 8'hDC;
	localparam logic [7:0] CMD_GOOD_HIGH   = 8'hE0;
	localparam logic [7:0] CMD_GOOD_LOW    = 8'hE1;
	localparam logic [7:0] CMD_STATUS      = 8'hF0;

	// reset values
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_SLEW = 8'h02;

	// field positions and widths
	localparam int unsigned EXT_SEL_BIT  = 3;
	localparam int unsigned OFS_SIGN_BIT = 5;
	localparam int unsigned LP_SEL_LO    = 6;
	localparam int unsigned SLEW_W       = 3;
	localparam int unsigned GOOD_HIGH_W  = 2;
	localparam int unsigned GOOD_LOW_W   = 3;
	localparam logic [1:0]  LP_TWO_PHASES = 2'h1;

	// offset trim: 6.25 mV per count, total clamped to 193.75 mV
	localparam int unsigned OFS_LSB_UV    = 6250;
	localparam int unsigned OFS_MAX_UV    = 193750;
	localparam int signed   OFS_MAX_COUNT = OFS_MAX_UV / OFS_LSB_UV;

	// power-good window in mV: high = 300 - 50*code, low = -(500 - 50*code)
	localparam int unsigned GOOD_HIGH_BASE_MV = 300;
	localparam int unsigned GOOD_LOW_BASE_MV  = 500;
	localparam int unsigned GOOD_STEP_MV      = 50;

	// transition slew: 1 + 2*code V/ms, i.e. uV per ns
	localparam int unsigned SLEW_BASE_VPMS = 1;
	localparam int unsigned SLEW_STEP_VPMS = 2;
	localparam int unsigned CODE_STEP_UV   = 6250;

	// minimum times, rounded up to whole cycles
	localparam int unsigned DEBOUNCE_NS     = 200;
	localparam int unsigned BLANK_NS        = 100000;
	localparam int unsigned OFF_CONFIRM_NS  = 5000;
	localparam int unsigned DEBOUNCE_CYC    = (DEBOUNCE_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned BLANK_CYC       = (BLANK_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned OFF_CONFIRM_CYC = (OFF_CONFIRM_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned BOOST_CYC       = 64;

	// phase masks
	localparam logic [3:0] PH_NONE  = 4'h0;
	localparam logic [3:0] PH_ONE   = 4'h1;
	localparam logic [3:0] PH_TWO   = 4'h3;
	localparam logic [3:0] PH_THREE = 4'h7;
	localparam logic [3:0] PH_FOUR  = 4'hF;
	localparam logic [3:0] PH_ODD   = 4'h5;
	localparam logic [2:0] CNT_THREE = 3'h3;
	localparam logic [2:0] CNT_FOUR  = 3'h4;

	typedef enum logic [1:0] {
		ST_OFF      = 2'h0,
		ST_SOFTSTART = 2'h1,
		ST_MASK     = 2'h3,
		ST_GOOD     = 2'h2
	} vpc_state_t;

	typedef struct packed {
		logic [7:0] outputCode;
		logic [7:0] lpPhase;
		logic [7:0] cfgA;
		logic [7:0] cfgB;
		logic [7:0] slew;
		logic [7:0] trim;
		logic [7:0] cal;
		logic [7:0] goodHigh;
		logic [7:0] goodLow;
	} vpc_regs_t;

	// pins and comparator results arriving from outside the clock domain
	typedef struct packed {
		logic enable;
		logic supplyOk;
		logic lowPowerRequest_n;
		logic aboveHigh;
		logic belowLow;
		logic belowRelease;
		logic softStartAtRef;
		logic loadStepUp;
		logic loadRelease;
	} vpc_sense_t;

	localparam int unsigned SENSE_W = $bits(vpc_sense_t);

endpackage

/* verilog/vpc_pin_sync.sv */
// three-flop pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module vpc_pin_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
		end else begin
			s1 <= d;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// per bit, so a lone disagreeing bit holds only itself
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else begin
			for (int i = 0; i < W; i++) begin
				if (s2[i] == s3[i]) begin
					q[i] <= s3[i];
				end
			end
		end
	end
endmodule
`default_nettype wire

/* verilog/vpc_hold_timer.sv */
// restartable hold timer: busy for CYCLES clocks after the last restart
`timescale 1ns/1ns
`default_nettype none
module vpc_hold_timer #(
	parameter int unsigned CYCLES = 1
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic restart,
	output var  logic busy,
	output var  logic expired
);
	logic [15:0] count;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count <= '0;
		end else if (restart) begin
			count <= 16'(CYCLES);
		end else if (count != '0) begin
			count <= count - 16'h0001;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			expired <= 1'b0;
		end else begin
			expired <= !restart && (count == 16'h0001);
		end
	end

	assign busy = (count != '0);
endmodule
`default_nettype wire

/* verilog/vpc_control.sv */
// reference selection, transition control, power-good and phase control of the regulator
// Behaviour
// - pins set the reference after reset; command code used once both select bits set
// - trim and calibration 6-bit offsets add 6.25 mV per count to reference
// - offset bit 5 clear means positive, set means negative magnitude bits 4:0
// - summed offset saturates at plus or minus 193.75 mV
// - after any code pin change, ignore pins for at least 200 ns
// - code change blanks power-good and clamp for 100 us; each change restarts it
// - transitions from pins or command, any steps either way, followed while running
// - off code must persist 5 us before controller shutdown
// - slew limited by 0xD6 bits 2:0, rate 1+2n V/ms, default 5
// - power-good low when out of window, no-processor code, or enable low
// - power-good held low until soft-start at reference and masking delay expired
// - upper window from 0xE0 bits 1:0: 300, 250, 200, 150 mV
// - lower window from 0xE1 bits 2:0: -500 mV up in 50 mV steps
// - low-power request low drives switched-phase disable low
// - 0xD1 bits 7:6 code 01 gives two low-power phases, else one
// - four normal phases and two low-power phases keep phases 1 and 3
// - overvoltage drives PWM low until output below about 300 mV
// - startup only with supply above undervoltage and enable high
// - while disabled, PWM held low, power-good and both disables low
// - load release drives release detect while running; load step re-enables shed phases
// - registers written by command code and data taken in the same cycle, as bus slave
`timescale 1ns/1ns
`default_nettype none
module vpc_control import vpc_pkg::*; #(
	parameter logic [7:0]  VID_OFF_CODE    = 8'h00,
	parameter logic [7:0]  VID_NO_CPU_CODE = 8'hFF,
	parameter int unsigned TURN_ON_MASK_CYC = 1000
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [7:0]  voltageIdCode,
	input  wire vpc_sense_t  senseIn,
	input  wire logic [2:0]  normalPhaseCount,
	input  wire logic        cmdWrite,
	input  wire logic        cmdRead,
	input  wire logic [7:0]  cmdCode,
	input  wire logic [7:0]  cmdData,
	output var  logic [7:0]  rdData,
	output var  logic        rdValid,
	output var  logic [7:0]  refCode,
	output var  logic [5:0]  offsetCount,
	output var  logic [9:0]  goodHighMv,
	output var  logic [9:0]  goodLowMv,
	output var  logic        codeTransition,
	output var  logic        outputInRangeFlag,
	output var  logic        pwmHoldLow,
	output var  logic        switchedPhaseDisable_n,
	output var  logic        alwaysOnPhaseDisable_n,
	output var  logic [3:0]  phaseEnable,
	output var  logic        releaseDetectOut
);
	vpc_regs_t        regs;
	vpc_sense_t       sense;
	logic [SENSE_W-1:0] senseBits;
	logic [7:0]       vidSync;
	logic [7:0]       vidPrev;
	logic [7:0]       acceptedVid;
	logic [7:0]       targetCode;
	logic [7:0]       targetPrev;
	logic             externalCodeSelect;
	logic             vidChanged;
	logic             targetChanged;
	logic             debExpired;
	logic             blanking;
	logic             offPresent;
	logic             offPrev;
	logic             offExpired;
	logic             offShutdown;
	logic             running;
	logic             maskExpired;
	logic             boostBusy;
	logic             crowbar;
	logic             next_crowbar;
	logic             lowPowerActive;
	logic [15:0]      slewCnt;
	logic [3:0]       normalMask;
	logic [3:0]       lowMask;
	logic [3:0]       next_phaseEnable;
	logic             next_inRange;
	logic [5:0]       next_offset;
	vpc_state_t       state;
	vpc_state_t       next_state;

	vpc_pin_sync #(.W(8)) uVidSync (
		.clk (clk),
		.rst (rst),
		.d   (voltageIdCode),
		.q   (vidSync)
	);

	vpc_pin_sync #(.W(SENSE_W)) uSenseSync (
		.clk (clk),
		.rst (rst),
		.d   (senseIn),
		.q   (senseBits)
	);

	assign sense = vpc_sense_t'(senseBits);

	// register writes; the command code selects the register the data lands in, both taken in one cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			regs <= '{RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_SLEW,
			           RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO};
		end else if (cmdWrite) begin
			unique case (cmdCode)
				CMD_OUTPUT_CODE: regs.outputCode <= cmdData;
				CMD_LP_PHASE:    regs.lpPhase <= cmdData;
				CMD_CFG_A:       regs.cfgA <= cmdData;
				CMD_CFG_B:       regs.cfgB <= cmdData;
				CMD_SLEW:        regs.slew <= cmdData;
				CMD_TRIM:        regs.trim <= cmdData;
				CMD_CAL:         regs.cal <= cmdData;
				CMD_GOOD_HIGH:   regs.goodHigh <= cmdData;
				CMD_GOOD_LOW:    regs.goodLow <= cmdData;
				default: ;
			endcase
		end
	end

	// reads answer one cycle later; unmapped codes read zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdData <= RST_ZERO;
			rdValid <= 1'b0;
		end else begin
			rdValid <= cmdRead;
			if (cmdRead) begin
				unique case (cmdCode)
					CMD_OUTPUT_CODE: rdData <= regs.outputCode;
					CMD_LP_PHASE:    rdData <= regs.lpPhase;
					CMD_CFG_A:       rdData <= regs.cfgA;
					CMD_CFG_B:       rdData <= regs.cfgB;
					CMD_SLEW:        rdData <= regs.slew;
					CMD_TRIM:        rdData <= regs.trim;
					CMD_CAL:         rdData <= regs.cal;
					CMD_GOOD_HIGH:   rdData <= regs.goodHigh;
					CMD_GOOD_LOW:    rdData <= regs.goodLow;
					CMD_STATUS:      rdData <= {state, offShutdown, crowbar, blanking,
					                            codeTransition, externalCodeSelect, running};
					default:         rdData <= RST_ZERO;
				endcase
			end
		end
	end

	// code pins: any change restarts the settle time, the code is taken when it ends
	assign vidChanged = (vidSync != vidPrev);

	vpc_hold_timer #(.CYCLES(DEBOUNCE_CYC)) uDebounce (
		.clk     (clk),
		.rst     (rst),
		.restart (vidChanged),
		.busy    (),
		.expired (debExpired)
	);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			vidPrev <= RST_ZERO;
			acceptedVid <= RST_ZERO;
		end else begin
			vidPrev <= vidSync;
			// a code that moves again in its last settle cycle is not yet stable
			if (debExpired && !vidChanged) begin
				acceptedVid <= vidSync;
			end
		end
	end

	// both select bits must be set; a single one keeps the pins in charge
	assign externalCodeSelect = regs.cfgA[EXT_SEL_BIT] && regs.cfgB[EXT_SEL_BIT];
	assign targetCode = externalCodeSelect ? regs.outputCode : acceptedVid;
	assign targetChanged = (targetCode != targetPrev);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			targetPrev <= RST_ZERO;
		end else begin
			targetPrev <= targetCode;
		end
	end

	vpc_hold_timer #(.CYCLES(BLANK_CYC)) uBlank (
		.clk     (clk),
		.rst     (rst),
		.restart (targetChanged),
		.busy    (blanking),
		.expired ()
	);

	// slew limit: one code step per interval derived from the programmed rate
	function automatic logic [15:0] slew_cycles(input logic [SLEW_W-1:0] code);
		int unsigned rate;
		rate = SLEW_BASE_VPMS + SLEW_STEP_VPMS * int'(code);
		return 16'((CODE_STEP_UV + rate * CLK_NS - 1) / (rate * CLK_NS));
	endfunction

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			refCode <= RST_ZERO;
			slewCnt <= '0;
		end else if (!running) begin
			// soft-start ramps from zero, so the reference simply follows
			refCode <= targetCode;
			slewCnt <= '0;
		end else if (refCode != targetCode) begin
			if (slewCnt == '0) begin
				refCode <= (targetCode > refCode) ? refCode + 8'h01 : refCode - 8'h01;
				slewCnt <= slew_cycles(regs.slew[SLEW_W-1:0]) - 16'h0001;
			end else begin
				slewCnt <= slewCnt - 16'h0001;
			end
		end else begin
			slewCnt <= '0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			codeTransition <= 1'b0;
		end else begin
			codeTransition <= running && (refCode != targetCode);
		end
	end

	// offsets: sign and magnitude, summed then clamped
	function automatic logic signed [7:0] ofs_value(input logic [7:0] f);
		logic signed [7:0] mag;
		mag = signed'({3'h0, f[OFS_SIGN_BIT-1:0]});
		return f[OFS_SIGN_BIT] ? -mag : mag;
	endfunction

	always_comb begin
		logic signed [7:0] sum;
		sum = ofs_value(regs.trim) + ofs_value(regs.cal);
		if (sum > 8'(OFS_MAX_COUNT)) begin
			next_offset = 6'(OFS_MAX_COUNT);
		end else if (sum < -8'(OFS_MAX_COUNT)) begin
			next_offset = 6'(-OFS_MAX_COUNT);
		end else begin
			next_offset = sum[5:0];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			offsetCount <= '0;
			goodHighMv <= 10'(GOOD_HIGH_BASE_MV);
			goodLowMv <= 10'(GOOD_LOW_BASE_MV);
		end else begin
			offsetCount <= next_offset;
			goodHighMv <= 10'(GOOD_HIGH_BASE_MV
			              - GOOD_STEP_MV * int'(regs.goodHigh[GOOD_HIGH_W-1:0]));
			goodLowMv <= 10'(GOOD_LOW_BASE_MV
			             - GOOD_STEP_MV * int'(regs.goodLow[GOOD_LOW_W-1:0]));
		end
	end

	// off code: confirmed only if still present when the wait ends
	assign offPresent = !externalCodeSelect && (acceptedVid == VID_OFF_CODE);

	vpc_hold_timer #(.CYCLES(OFF_CONFIRM_CYC)) uOffConfirm (
		.clk     (clk),
		.rst     (rst),
		.restart (offPresent && !offPrev),
		.busy    (),
		.expired (offExpired)
	);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			offPrev <= 1'b0;
			offShutdown <= 1'b0;
		end else begin
			offPrev <= offPresent;
			if (!offPresent) begin
				offShutdown <= 1'b0;
			end else if (offExpired) begin
				offShutdown <= 1'b1;
			end
		end
	end

	assign running = sense.enable && sense.supplyOk && !offShutdown;

	// startup sequence: soft-start, then the turn-on masking delay
	always_comb begin
		next_state = state;
		unique case (state)
			ST_OFF:       next_state = ST_SOFTSTART;
			ST_SOFTSTART: if (sense.softStartAtRef) next_state = ST_MASK;
			ST_MASK:      if (maskExpired) next_state = ST_GOOD;
			ST_GOOD:      next_state = ST_GOOD;
		endcase
		if (!running) begin
			next_state = ST_OFF;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= ST_OFF;
		end else begin
			state <= next_state;
		end
	end

	vpc_hold_timer #(.CYCLES(TURN_ON_MASK_CYC)) uTurnOnMask (
		.clk     (clk),
		.rst     (rst),
		.restart (state == ST_SOFTSTART && next_state == ST_MASK),
		.busy    (),
		.expired (maskExpired)
	);

	// window faults are ignored while a transition is being blanked
	assign next_inRange = running && (state == ST_GOOD)
	                      && (acceptedVid != VID_NO_CPU_CODE)
	                      && (blanking || !(sense.aboveHigh || sense.belowLow));

	// clamp threshold tracks the upper window; release near 300 mV
	always_comb begin
		next_crowbar = crowbar;
		if (sense.belowRelease) begin
			next_crowbar = 1'b0;
		end else if (sense.aboveHigh && !blanking) begin
			next_crowbar = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			crowbar <= 1'b0;
			outputInRangeFlag <= 1'b0;
			pwmHoldLow <= 1'b1;
			releaseDetectOut <= 1'b0;
		end else begin
			crowbar <= next_crowbar;
			outputInRangeFlag <= next_inRange;
			pwmHoldLow <= !running || next_crowbar;
			releaseDetectOut <= running && sense.loadRelease;
		end
	end

	// phase shedding; a load step brings shed phases back for a while
	assign lowPowerActive = !sense.lowPowerRequest_n && !boostBusy;

	vpc_hold_timer #(.CYCLES(BOOST_CYC)) uStepBoost (
		.clk     (clk),
		.rst     (rst),
		.restart (sense.loadStepUp),
		.busy    (boostBusy),
		.expired ()
	);

	always_comb begin
		unique case (normalPhaseCount)
			CNT_FOUR:  normalMask = PH_FOUR;
			CNT_THREE: normalMask = PH_THREE;
			default:   normalMask = PH_TWO;
		endcase
		if (regs.lpPhase[LP_SEL_LO +: 2] == LP_TWO_PHASES) begin
			lowMask = (normalPhaseCount == CNT_FOUR) ? PH_ODD : PH_TWO;
		end else begin
			lowMask = PH_ONE;
		end
		if (!running) begin
			next_phaseEnable = PH_NONE;
		end else if (lowPowerActive) begin
			next_phaseEnable = lowMask;
		end else begin
			next_phaseEnable = normalMask;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			phaseEnable <= PH_NONE;
			switchedPhaseDisable_n <= 1'b0;
			alwaysOnPhaseDisable_n <= 1'b0;
		end else begin
			phaseEnable <= next_phaseEnable;
			switchedPhaseDisable_n <= running && !lowPowerActive;
			alwaysOnPhaseDisable_n <= running;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_pin_change;
		vidChanged;
	endsequence

	sequence s_settle_quiet;
		$stable(acceptedVid) [*5];
	endsequence

	a_pin_settle: assert property (s_pin_change |=> s_settle_quiet)
		else $error("code accepted before settle time");

	a_source_select: assert property (!(regs.cfgA[EXT_SEL_BIT] && regs.cfgB[EXT_SEL_BIT])
		|-> targetCode == acceptedVid)
		else $error("pins not selected without both select bits");

	a_offset_clamp: assert property ($signed(offsetCount) <= 6'sd31 && $signed(offsetCount) >= -6'sd31)
		else $error("offset outside clamp");

	a_offset_sign: assert property (!regs.trim[OFS_SIGN_BIT] && !regs.cal[OFS_SIGN_BIT]
		|=> !offsetCount[OFS_SIGN_BIT])
		else $error("positive offsets wrapped negative");

	a_blank_hold: assert property (targetChanged |=> blanking [*8])
		else $error("blanking not started on code change");

	a_slew_step: assert property (running && $past(running) && $changed(refCode)
		|-> $past(slewCnt) == '0)
		else $error("reference stepped before slew interval");

	a_disable_outputs: assert property (!running |=> !outputInRangeFlag && pwmHoldLow
		&& !switchedPhaseDisable_n && !alwaysOnPhaseDisable_n)
		else $error("outputs not forced low while disabled");

	a_good_after_mask: assert property ($rose(outputInRangeFlag) |-> $past(state) == ST_GOOD)
		else $error("power-good before masking delay");

	a_crowbar_pwm: assert property (crowbar |-> pwmHoldLow)
		else $error("pwm not held low during clamp");

	a_low_power_shed: assert property (running && !sense.lowPowerRequest_n && !boostBusy
		|=> !switchedPhaseDisable_n)
		else $error("switched phases not disabled in low power");

	a_off_confirm: assert property ($rose(offShutdown) |-> $past(offExpired))
		else $error("shutdown without confirmed off code");
endmodule
`default_nettype wire

/* tb/vpc_cpu_model.sv */
// processor side model: drives the code pins toward a requested code with skew
`timescale 1ns/1ns
`default_nettype none
module vpc_cpu_model (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [7:0] wantCode,
	output var  logic [7:0] voltageIdCode
);
	// low nibble lands one cycle before the high nibble, like skewed board traces
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			voltageIdCode <= wantCode;
		end else if (voltageIdCode[3:0] != wantCode[3:0]) begin
			voltageIdCode[3:0] <= wantCode[3:0];
		end else begin
			voltageIdCode[7:4] <= wantCode[7:4];
		end
	end
endmodule
`default_nettype wire

/* tb/vpc_control_bench.sv */
// self-checking bench for the reference, power-good and phase control block
`timescale 1ns/1ns
`default_nettype none
module vpc_control_bench import vpc_pkg::*; ;
	logic       clk;
	logic       rst = 1'b0;
	logic [7:0] wantCode = 8'h30;
	logic [7:0] voltageIdCode;
	// low-power request idles high
	vpc_sense_t sense = 9'h040;
	logic [2:0] normalPhaseCount = 3'h4;
	logic       cmdWrite = 1'b0;
	logic       cmdRead = 1'b0;
	logic [7:0] cmdCode = 8'h00;
	logic [7:0] cmdData = 8'h00;
	logic [7:0] rdData, refCode;
	logic [5:0] offsetCount;
	logic [9:0] goodHighMv, goodLowMv;
	logic       rdValid, codeTransition, outputInRangeFlag, pwmHoldLow;
	logic       switchedPhaseDisable_n, alwaysOnPhaseDisable_n, releaseDetectOut;
	logic [3:0] phaseEnable;
	int         n_mismatch = 0;
	int         cmp_count = 0;
	int         i;
	logic [7:0] cmds [10] = '{8'h21, 8'hD1, 8'hD2, 8'hD3, 8'hD6, 8'hDB, 8'hDC, 8'hE0, 8'hE1, 8'h30};
	// trim, calibration, expected signed count
	logic [23:0] ofs [5] = '{24'h08020A, 24'h212E31, 24'h0F210E, 24'h1F1F1F, 24'h3F3F21};

	vpc_cpu_model cpu_u (
		.clk           (clk),
		.rst           (rst),
		.wantCode      (wantCode),
		.voltageIdCode (voltageIdCode)
	);

	vpc_control #(.TURN_ON_MASK_CYC(8)) dut_u (
		.clk                    (clk),
		.rst                    (rst),
		.voltageIdCode          (voltageIdCode),
		.senseIn                (sense),
		.normalPhaseCount       (normalPhaseCount),
		.cmdWrite               (cmdWrite),
		.cmdRead                (cmdRead),
		.cmdCode                (cmdCode),
		.cmdData                (cmdData),
		.rdData                 (rdData),
		.rdValid                (rdValid),
		.refCode                (refCode),
		.offsetCount            (offsetCount),
		.goodHighMv             (goodHighMv),
		.goodLowMv              (goodLowMv),
		.codeTransition         (codeTransition),
		.outputInRangeFlag      (outputInRangeFlag),
		.pwmHoldLow             (pwmHoldLow),
		.switchedPhaseDisable_n (switchedPhaseDisable_n),
		.alwaysOnPhaseDisable_n (alwaysOnPhaseDisable_n),
		.phaseEnable            (phaseEnable),
		.releaseDetectOut       (releaseDetectOut)
	);

	task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chkb(input string nm, input logic e, input logic g);
		chk(nm, {9'h000, e}, {9'h000, g});
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wr(input logic [7:0] c, input logic [7:0] d);
		@(posedge clk);
		cmdWrite <= 1'b1;
		cmdCode <= c;
		cmdData <= d;
		@(posedge clk);
		cmdWrite <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] c, input logic [7:0] e);
		@(posedge clk);
		cmdRead <= 1'b1;
		cmdCode <= c;
		@(posedge clk);
		cmdRead <= 1'b0;
		#1;
		chkb("rdValid", 1'b1, rdValid);
		chk("rdData", {2'h0, e}, {2'h0, rdData});
	endtask

	task automatic stop_test;
		$display("checks %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// the whole sequence needs about 3500 cycles
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		stop_test();
	end

	initial begin
		rst = 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk("goodHigh", 10'h12C, goodHighMv);
		chk("goodLow", 10'h1F4, goodLowMv);
		chkb("pwmHold", 1'b1, pwmHoldLow);
		chkb("swDis", 1'b0, switchedPhaseDisable_n);
		chkb("onDis", 1'b0, alwaysOnPhaseDisable_n);
		wr(8'h30, 8'h55);
		for (i = 0; i < 10; i++) rd(cmds[i], (cmds[i] == 8'hD6) ? 8'h02 : 8'h00);
		chk("refCode", 10'h030, {2'h0, refCode});
		for (i = 0; i < 5; i++) begin
			wr(CMD_TRIM, {2'h0, ofs[i][21:16]});
			wr(CMD_CAL, {2'h0, ofs[i][13:8]});
			tick(3);
			chk("offset", {4'h0, ofs[i][5:0]}, {4'h0, offsetCount});
		end
		for (i = 0; i < 4; i++) begin
			wr(CMD_GOOD_HIGH, 8'(i));
			tick(3);
			chk("goodHigh", 10'(300 - 50 * i), goodHighMv);
		end
		for (i = 0; i < 8; i++) begin
			wr(CMD_GOOD_LOW, 8'(i));
			tick(3);
			chk("goodLow", 10'(500 - 50 * i), goodLowMv);
		end
		wr(CMD_SLEW, 8'h07);
		rd(CMD_SLEW, 8'h07);
		@(posedge clk);
		sense.enable <= 1'b1;
		sense.supplyOk <= 1'b1;
		sense.softStartAtRef <= 1'b1;
		tick(8);
		chkb("inRange", 1'b0, outputInRangeFlag);
		for (i = 0; i < 200 && outputInRangeFlag !== 1'b1; i++) tick(1);
		chkb("inRange", 1'b1, outputInRangeFlag);
		chkb("pwmHold", 1'b0, pwmHoldLow);
		chk("phases", 10'h00F, {6'h00, phaseEnable});
		wr(CMD_LP_PHASE, 8'h40);
		@(posedge clk);
		sense.lowPowerRequest_n <= 1'b0;
		tick(8);
		chkb("swDis", 1'b0, switchedPhaseDisable_n);
		chk("phases", 10'h005, {6'h00, phaseEnable});
		@(posedge clk);
		normalPhaseCount <= 3'h3;
		tick(2);
		chk("phases", 10'h003, {6'h00, phaseEnable});
		@(posedge clk);
		normalPhaseCount <= 3'h4;
		wr(CMD_LP_PHASE, 8'hC0);
		tick(3);
		chk("phases", 10'h001, {6'h00, phaseEnable});
		@(posedge clk);
		sense.loadStepUp <= 1'b1;
		tick(8);
		chk("phases", 10'h00F, {6'h00, phaseEnable});
		@(posedge clk);
		sense.loadStepUp <= 1'b0;
		sense.lowPowerRequest_n <= 1'b1;
		sense.loadRelease <= 1'b1;
		tick(8);
		chkb("release", 1'b1, releaseDetectOut);
		@(posedge clk);
		sense.loadRelease <= 1'b0;
		wantCode <= 8'h38;
		tick(16);
		chkb("moving", 1'b1, codeTransition);
		for (i = 0; i < 400 && codeTransition !== 1'b0; i++) tick(1);
		// eight codes at 11 cycles each, counted from well after the change
		chkb("slewTime", 1'b1, i > 60 && i < 100);
		chk("refCode", 10'h038, {2'h0, refCode});
		@(posedge clk);
		sense.aboveHigh <= 1'b1;
		tick(8);
		chkb("inRange", 1'b1, outputInRangeFlag);
		chkb("pwmHold", 1'b0, pwmHoldLow);
		tick(2500);
		chkb("inRange", 1'b0, outputInRangeFlag);
		chkb("pwmHold", 1'b1, pwmHoldLow);
		@(posedge clk);
		sense.aboveHigh <= 1'b0;
		sense.belowRelease <= 1'b1;
		tick(8);
		chkb("pwmHold", 1'b0, pwmHoldLow);
		chkb("inRange", 1'b1, outputInRangeFlag);
		@(posedge clk);
		sense.belowRelease <= 1'b0;
		sense.belowLow <= 1'b1;
		tick(8);
		chkb("inRange", 1'b0, outputInRangeFlag);
		chkb("pwmHold", 1'b0, pwmHoldLow);
		@(posedge clk);
		sense.belowLow <= 1'b0;
		wr(CMD_OUTPUT_CODE, 8'h50);
		wr(CMD_CFG_A, 8'h08);
		tick(20);
		chk("refCode", 10'h038, {2'h0, refCode});
		wr(CMD_CFG_B, 8'h08);
		tick(4);
		for (i = 0; i < 400 && codeTransition !== 1'b0; i++) tick(1);
		chk("refCode", 10'h050, {2'h0, refCode});
		wr(CMD_CFG_A, 8'h00);
		@(posedge clk);
		wantCode <= 8'hFF;
		tick(30);
		chkb("inRange", 1'b0, outputInRangeFlag);
		@(posedge clk);
		wantCode <= 8'h00;
		tick(60);
		chkb("pwmHold", 1'b0, pwmHoldLow);
		tick(100);
		chkb("pwmHold", 1'b1, pwmHoldLow);
		@(posedge clk);
		wantCode <= 8'h38;
		tick(30);
		chkb("pwmHold", 1'b0, pwmHoldLow);
		chkb("onDis", 1'b1, alwaysOnPhaseDisable_n);
		@(posedge clk);
		sense.enable <= 1'b0;
		tick(8);
		chkb("pwmHold", 1'b1, pwmHoldLow);
		chkb("swDis", 1'b0, switchedPhaseDisable_n);
		chkb("onDis", 1'b0, alwaysOnPhaseDisable_n);
		// status: state off, blanking still running from the last code change
		rd(CMD_STATUS, 8'h08);
		stop_test();
	end
endmodule
`default_nettype wire
